//--- hdl/p3g_port3.sv
/*
  p3g_port3: port 3 general i/o with per-pin alternate function routing.
  holds the data latch, direction, pull-up and function select registers,
  the register read path, and the registered pad and function signals.
  assumes: a plain one-cycle register port on core_clk; pad pins are
  asynchronous and synchronised here; on-chip function signals share
  core_clk; the pad ring resolves pad_out and pad_oe into the wire.
*/
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
module p3g_port3
  import p3g_pkg::*;
#(
  parameter int PINS = P3G_PINS,
  parameter int SYNC_STAGES = P3G_SYNC_STAGES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [P3G_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  // package pins
  input wire logic [PINS-1:0] pad_in,
  output logic [PINS-1:0] pad_out,
  output logic [PINS-1:0] pad_oe,
  output logic [PINS-1:0] pad_pullup,
  // on-chip function side
  input wire logic strobe_out,
  input wire logic serial_two_data_out,
  input wire logic serial_two_clock_out,
  input wire logic [2:0] serial_clock_source_field,
  input wire logic serial_one_data_out,
  input wire logic serial_one_clock_out,
  input wire logic serial_one_clock_oe,
  output logic chip_select_n,
  output logic serial_two_data_in,
  output logic serial_two_clock_in,
  output logic serial_one_data_in,
  output logic serial_one_clock_in
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // the function map is fixed to eight pins
  if (PINS != P3G_PINS) begin : g_chk_pins
    $error("p3g_port3 supports exactly eight pins");
  end

  // a single flop would not settle a pad level
  if (SYNC_STAGES < 2) begin : g_chk_sync
    $error("p3g_port3 needs at least two sync stages");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0] data_latch_ff;
  logic [7:0] dir_ctrl_ff;
  logic [7:0] pullup_ctrl_ff;
  logic [7:0] func_sel_ff;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;
  logic [PINS-1:0] pad_out_ff;
  logic [PINS-1:0] pad_oe_ff;
  logic [PINS-1:0] pad_pullup_ff;
  logic [PINS-1:0] nxt_pad_out;
  logic [PINS-1:0] nxt_pad_oe;
  logic [PINS-1:0] nxt_pad_pullup;
  logic [PINS-1:0] pin_level;
  logic [PINS-1:0] port_read_val;
  logic [PINS-1:0] alt_out;
  logic [PINS-1:0] alt_oe;
  logic chip_select_n_ff;
  logic serial_two_data_in_ff;
  logic serial_two_clock_in_ff;
  logic serial_one_data_in_ff;
  logic serial_one_clock_in_ff;
  logic clk_two_ext_in;
  logic sel_func_sel;
  logic sel_data_latch;
  logic sel_pullup;
  logic sel_dir;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // full 16-bit compare so aliases never hit a register
  assign sel_func_sel = (reg_addr == P3G_FUNC_SEL_ADDR);
  assign sel_data_latch = (reg_addr == P3G_DATA_LATCH_ADDR);
  assign sel_pullup = (reg_addr == P3G_PULLUP_ADDR);
  assign sel_dir = (reg_addr == P3G_DIR_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // output data latch
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      data_latch_ff <= P3G_REG_RESET;
    end else if (reg_wr_en && sel_data_latch) begin
      data_latch_ff <= reg_wr_data;
    end
  end

  // direction register; reads back as all ones, but its bits pick latch or pin level on data reads
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dir_ctrl_ff <= P3G_REG_RESET;
    end else if (reg_wr_en && sel_dir) begin
      dir_ctrl_ff <= reg_wr_data;
    end
  end

  // pull-up enables
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pullup_ctrl_ff <= P3G_REG_RESET;
    end else if (reg_wr_en && sel_pullup) begin
      pullup_ctrl_ff <= reg_wr_data;
    end
  end

  // function select
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      func_sel_ff <= P3G_REG_RESET;
    end else if (reg_wr_en && sel_func_sel) begin
      func_sel_ff <= reg_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad input synchronisation

  // pad levels are asynchronous to core_clk
  p3g_sync #(
    .WIDTH(PINS),
    .STAGES(SYNC_STAGES)
  ) u_pad_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(pad_in),
    .sync_out(pin_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path

  // per-bit choice between latch and pin level
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (dir_ctrl_ff[i]) begin
        port_read_val[i] = data_latch_ff[i];
      end else begin
        port_read_val[i] = pin_level[i];
      end
    end
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    nxt_rd_data = P3G_UNMAPPED_VAL;
    if (sel_data_latch) begin
      nxt_rd_data = port_read_val;
    end else if (sel_dir) begin
      nxt_rd_data = P3G_DIR_READ_VAL;
    end else if (sel_pullup) begin
      nxt_rd_data = pullup_ctrl_ff;
    end else if (sel_func_sel) begin
      nxt_rd_data = func_sel_ff;
    end
  end

  // read data stands one cycle only, zero otherwise
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data_ff <= P3G_UNMAPPED_VAL;
    end else if (reg_rd_en) begin
      rd_data_ff <= nxt_rd_data;
    end else begin
      rd_data_ff <= P3G_UNMAPPED_VAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alternate function drive sources

  assign clk_two_ext_in = (serial_clock_source_field == P3G_CKS_EXT_IN);

  // gather drive values and enables; input-only pins carry zero
  always_comb begin
    alt_out = '0;
    alt_oe = '0;
    alt_out[P3G_PIN_STROBE] = strobe_out;
    alt_out[P3G_PIN_DOUT_TWO] = serial_two_data_out;
    alt_out[P3G_PIN_CLK_TWO] = serial_two_clock_out;
    alt_oe[P3G_PIN_CLK_TWO] = !clk_two_ext_in;
    alt_out[P3G_PIN_DOUT_ONE] = serial_one_data_out;
    alt_out[P3G_PIN_CLK_ONE] = serial_one_clock_out;
    alt_oe[P3G_PIN_CLK_ONE] = serial_one_clock_oe;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin routing

  for (genvar g = 0; g < PINS; g++) begin : g_pin
    p3g_pin_cell #(
      .KIND(P3G_PIN_KIND[g])
    ) u_cell (
      .func_sel(func_sel_ff[g]),
      .dir(dir_ctrl_ff[g]),
      .latch(data_latch_ff[g]),
      .alt_out(alt_out[g]),
      .alt_oe(alt_oe[g]),
      .nxt_pad_out(nxt_pad_out[g]),
      .nxt_pad_oe(nxt_pad_oe[g])
    );
  end

  // pull-up on undriven pins whose direction bit is clear
  // a driven pin never gets the pull-up, so no fight with the driver
  assign nxt_pad_pullup = pullup_ctrl_ff & ~dir_ctrl_ff & ~nxt_pad_oe;

  ////////////////////////////////////////////////////////////////////////////
  // registered pad controls

  // registering costs a cycle but keeps the pads glitch free
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pad_out_ff <= '0;
    end else begin
      pad_out_ff <= nxt_pad_out;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pad_oe_ff <= '0;
    end else begin
      pad_oe_ff <= nxt_pad_oe;
    end
  end

  // pull-up controls, off in reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pad_pullup_ff <= '0;
    end else begin
      pad_pullup_ff <= nxt_pad_pullup;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // inputs handed to on-chip functions

  // unselected functions see an idle high level
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chip_select_n_ff <= P3G_IDLE_IN;
    end else if (func_sel_ff[P3G_PIN_CS]) begin
      chip_select_n_ff <= pin_level[P3G_PIN_CS];
    end else begin
      chip_select_n_ff <= P3G_IDLE_IN;
    end
  end

  // channel two data in
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      serial_two_data_in_ff <= P3G_IDLE_IN;
    end else if (func_sel_ff[P3G_PIN_DIN_TWO]) begin
      serial_two_data_in_ff <= pin_level[P3G_PIN_DIN_TWO];
    end else begin
      serial_two_data_in_ff <= P3G_IDLE_IN;
    end
  end

  // channel two clock in, only while the pin is a clock input
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      serial_two_clock_in_ff <= P3G_IDLE_IN;
    end else if (func_sel_ff[P3G_PIN_CLK_TWO] && clk_two_ext_in) begin
      serial_two_clock_in_ff <= pin_level[P3G_PIN_CLK_TWO];
    end else begin
      serial_two_clock_in_ff <= P3G_IDLE_IN;
    end
  end

  // channel one data in
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      serial_one_data_in_ff <= P3G_IDLE_IN;
    end else if (func_sel_ff[P3G_PIN_DIN_ONE]) begin
      serial_one_data_in_ff <= pin_level[P3G_PIN_DIN_ONE];
    end else begin
      serial_one_data_in_ff <= P3G_IDLE_IN;
    end
  end

  // channel one clock in while the channel is not driving it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      serial_one_clock_in_ff <= P3G_IDLE_IN;
    end else if (func_sel_ff[P3G_PIN_CLK_ONE] && !serial_one_clock_oe) begin
      serial_one_clock_in_ff <= pin_level[P3G_PIN_CLK_ONE];
    end else begin
      serial_one_clock_in_ff <= P3G_IDLE_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rd_data = rd_data_ff;
  assign pad_out = pad_out_ff;
  assign pad_oe = pad_oe_ff;
  assign pad_pullup = pad_pullup_ff;
  assign chip_select_n = chip_select_n_ff;
  assign serial_two_data_in = serial_two_data_in_ff;
  assign serial_two_clock_in = serial_two_clock_in_ff;
  assign serial_one_data_in = serial_one_data_in_ff;
  assign serial_one_clock_in = serial_one_clock_in_ff;

endmodule

//--- hdl/p3g_pkg.sv
/*
  p3g_pkg: constants shared by the port 3 pin multiplexer files.
  assumes: 16-bit register addresses and 8-bit register data.
*/
package p3g_pkg;
  localparam int P3G_PINS = 8;
  localparam int P3G_ADDR_W = 16;
  localparam int P3G_SYNC_STAGES = 2;

  // register addresses as printed
  localparam logic [15:0] P3G_FUNC_SEL_ADDR = 16'hffca;
  localparam logic [15:0] P3G_DATA_LATCH_ADDR = 16'hffd6;
  localparam logic [15:0] P3G_PULLUP_ADDR = 16'hffe1;
  localparam logic [15:0] P3G_DIR_ADDR = 16'hffe6;

  // reset and fixed read values
  localparam logic [7:0] P3G_REG_RESET = 8'h00;
  localparam logic [7:0] P3G_DIR_READ_VAL = 8'hff;
  localparam logic [7:0] P3G_UNMAPPED_VAL = 8'h00;

  // pin positions of the alternate functions
  localparam int P3G_PIN_CLK_ONE = 0;
  localparam int P3G_PIN_DIN_ONE = 1;
  localparam int P3G_PIN_DOUT_ONE = 2;
  localparam int P3G_PIN_CLK_TWO = 3;
  localparam int P3G_PIN_DIN_TWO = 4;
  localparam int P3G_PIN_DOUT_TWO = 5;
  localparam int P3G_PIN_STROBE = 6;
  localparam int P3G_PIN_CS = 7;

  // clock source code that makes channel 2 take its clock from the pin
  localparam logic [2:0] P3G_CKS_EXT_IN = 3'h7;
  // level handed to an on-chip function whose pin is not selected
  localparam logic P3G_IDLE_IN = 1'b1;

  // kind of alternate function on a pin, one-hot
  typedef enum logic [2:0] {
    P3G_ALT_IN = 3'b001,
    P3G_ALT_OUT = 3'b010,
    P3G_ALT_BIDIR = 3'b100
  } p3g_kind_t;

  // kind per pin, index 0 is pin 0
  localparam p3g_kind_t P3G_PIN_KIND [0:7] = '{
    P3G_ALT_BIDIR, P3G_ALT_IN, P3G_ALT_OUT, P3G_ALT_BIDIR,
    P3G_ALT_IN, P3G_ALT_OUT, P3G_ALT_OUT, P3G_ALT_IN
  };
endpackage

//--- hdl/p3g_sync.sv
/*
  p3g_sync: multi-bit level synchroniser for the package pin inputs.
  assumes: each bit is an independent level; no bus coherency needed.
*/
`timescale 1ns/10ps
module p3g_sync
  import p3g_pkg::*;
#(
  parameter int WIDTH = P3G_PINS,
  parameter int STAGES = P3G_SYNC_STAGES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_ff [0:STAGES-1];

  // fewer than two stages would leave metastability exposed
  if (STAGES < 2) begin : g_chk
    $error("p3g_sync needs at least two stages");
  end

  // shift chain; only the next stage reads the first flop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_ff[i] <= '0;
      end
    end else begin
      stage_ff[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        stage_ff[i] <= stage_ff[i-1];
      end
    end
  end

  assign sync_out = stage_ff[STAGES-1];
endmodule

//--- hdl/p3g_pin_cell.sv
/*
  p3g_pin_cell: next drive value and enable for one port pin.
  assumes: the caller registers both results before they reach the pad.
*/
`timescale 1ns/10ps
module p3g_pin_cell
  import p3g_pkg::*;
#(
  parameter p3g_kind_t KIND = P3G_ALT_IN
) (
  input wire logic func_sel,
  input wire logic dir,
  input wire logic latch,
  input wire logic alt_out,
  input wire logic alt_oe,
  output logic nxt_pad_out,
  output logic nxt_pad_oe
);
  // general i/o when not selected, else the alternate function owns the pin
  always_comb begin
    nxt_pad_out = 1'b0;
    nxt_pad_oe = 1'b0;
    if (!func_sel) begin
      nxt_pad_oe = dir;
      nxt_pad_out = latch;
    end else begin
      case (KIND)
        P3G_ALT_IN: begin
          nxt_pad_oe = 1'b0;
          nxt_pad_out = 1'b0;
        end
        P3G_ALT_OUT: begin
          nxt_pad_oe = 1'b1;
          nxt_pad_out = alt_out;
        end
        P3G_ALT_BIDIR: begin
          nxt_pad_oe = alt_oe;
          nxt_pad_out = alt_out;
        end
        default: begin
          nxt_pad_oe = 1'b0;
          nxt_pad_out = 1'b0;
        end
      endcase
    end
  end
endmodule

//--- verif/p3g_port3_checker.sv
/*
  p3g_port3_checker: port-level assertions for the port 3 pin multiplexer.
  assumes: bound to p3g_port3; register contents are mirrored from the write port.
*/
`timescale 1ns/10ps
module p3g_port3_checker
  import p3g_pkg::*;
#(
  parameter int PINS = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [P3G_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic [PINS-1:0] pad_in,
  input wire logic [PINS-1:0] pad_out,
  input wire logic [PINS-1:0] pad_oe,
  input wire logic [PINS-1:0] pad_pullup,
  input wire logic strobe_out,
  input wire logic serial_two_data_out,
  input wire logic serial_two_clock_out,
  input wire logic [2:0] serial_clock_source_field,
  input wire logic serial_one_data_out,
  input wire logic serial_one_clock_out,
  input wire logic serial_one_clock_oe,
  input wire logic chip_select_n,
  input wire logic serial_two_data_in,
  input wire logic serial_two_clock_in,
  input wire logic serial_one_data_in,
  input wire logic serial_one_clock_in
);
  logic [7:0] sel_ff, dir_ff, pu_ff, lat_ff, pd1_ff, pd2_ff;
  logic [7:0] alt_oe, alt_out, exp_oe, exp_out, exp_pu;
  logic [4:0] exp_fin;
  logic [2:0] up_ff;
  logic rd_ok;

  //////////////////////////////////////////////////////////////////////////////
  // register mirror, updated on the same edge as the block's own registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sel_ff <= 8'h00;
      dir_ff <= 8'h00;
      pu_ff <= 8'h00;
      lat_ff <= 8'h00;
    end else if (reg_wr_en) begin
      if (reg_addr == P3G_FUNC_SEL_ADDR) sel_ff <= reg_wr_data;
      if (reg_addr == P3G_DIR_ADDR) dir_ff <= reg_wr_data;
      if (reg_addr == P3G_PULLUP_ADDR) pu_ff <= reg_wr_data;
      if (reg_addr == P3G_DATA_LATCH_ADDR) lat_ff <= reg_wr_data;
    end
  end

  // edges since reset; synchronised pin checks wait until the flops hold real samples
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      up_ff <= 3'h0;
    end else if (up_ff != 3'h7) begin
      up_ff <= up_ff + 3'h1;
    end
  end

  // pin delay line matching the two-stage synchroniser
  always_ff @(posedge core_clk) begin
    pd1_ff <= pad_in;
    pd2_ff <= pd1_ff;
  end

  // expected pad drive per pin: alternate function wins over general i/o
  assign alt_oe = {3'b011, 1'b0, serial_clock_source_field != P3G_CKS_EXT_IN, 2'b10,
                   serial_one_clock_oe};
  assign alt_out = {1'b0, strobe_out, serial_two_data_out, 1'b0, serial_two_clock_out,
                    serial_one_data_out, 1'b0, serial_one_clock_out};
  assign exp_oe = (sel_ff & alt_oe) | (~sel_ff & dir_ff);
  assign exp_out = (sel_ff & alt_out) | (~sel_ff & lat_ff);
  assign exp_pu = pu_ff & ~dir_ff & ~exp_oe;
  assign exp_fin = {sel_ff[7] ? pd2_ff[7] : 1'b1, sel_ff[4] ? pd2_ff[4] : 1'b1,
                    (sel_ff[3] && serial_clock_source_field == P3G_CKS_EXT_IN) ? pd2_ff[3] : 1'b1,
                    sel_ff[1] ? pd2_ff[1] : 1'b1,
                    (sel_ff[0] && !serial_one_clock_oe) ? pd2_ff[0] : 1'b1};
  assign rd_ok = reg_rd_en && reg_addr == P3G_DATA_LATCH_ADDR;

  //////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  AST_RD_IDLE_ZERO: assert property (!reg_rd_en |=> reg_rd_data == 8'h00)
    else $error("read data not zero after idle cycle");
  AST_DIR_READS_ONES: assert property (reg_rd_en && reg_addr == P3G_DIR_ADDR
    |=> reg_rd_data == 8'hff) else $error("direction register did not read all ones");
  AST_UNMAPPED_ZERO: assert property (reg_rd_en && reg_addr != P3G_DIR_ADDR
    && reg_addr != P3G_FUNC_SEL_ADDR && reg_addr != P3G_PULLUP_ADDR && !rd_ok
    |=> reg_rd_data == 8'h00) else $error("unmapped read returned data");
  AST_RD_OUT_BITS: assert property (rd_ok |=> (reg_rd_data & $past(dir_ff))
    == $past(dir_ff & lat_ff)) else $error("output pin read is not latch value");
  AST_RD_IN_BITS: assert property (rd_ok && up_ff == 3'h7
    |=> (reg_rd_data & ~$past(dir_ff)) == $past(~dir_ff & pd2_ff))
    else $error("input pin read is not pin level");
  AST_PAD_OE: assert property (up_ff != 3'h0
    |-> pad_oe == $past(exp_oe)) else $error("pad enable wrong");
  AST_PAD_OUT: assert property (up_ff != 3'h0
    |-> (pad_out & pad_oe) == $past(exp_out & exp_oe)) else $error("pad drive value wrong");
  AST_PULLUP: assert property (up_ff != 3'h0 |-> pad_pullup == $past(exp_pu))
    else $error("pull-up state wrong");
  AST_FUNC_IN: assert property (
    up_ff == 3'h7 |-> {chip_select_n, serial_two_data_in, serial_two_clock_in,
    serial_one_data_in, serial_one_clock_in} == $past(exp_fin))
    else $error("function input wrong");
endmodule

bind p3g_port3 p3g_port3_checker #(.PINS(PINS)) i_chk (.core_clk, .rst_n, .reg_addr,
  .reg_wr_data, .reg_wr_en, .reg_rd_en, .reg_rd_data, .pad_in, .pad_out, .pad_oe, .pad_pullup,
  .strobe_out, .serial_two_data_out, .serial_two_clock_out, .serial_clock_source_field,
  .serial_one_data_out, .serial_one_clock_out, .serial_one_clock_oe, .chip_select_n,
  .serial_two_data_in, .serial_two_clock_in, .serial_one_data_in, .serial_one_clock_in);

//--- verif/p3g_pin_world.sv
/*
  p3g_pin_world: the board around the port 3 pads.
  assumes: driving pad wins; otherwise an external driver, then the pull-up.
*/
`timescale 1ns/10ps
module p3g_pin_world (
  input wire logic core_clk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pad_in
);
  logic [7:0] float_ff;

  // a floating pin never holds its level, so stale data cannot pass for a match
  always_ff @(posedge core_clk) begin
    float_ff <= ~pad_in;
  end

  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en & (pad_pullup | float_ff));
endmodule

//--- verif/p3g_port3_bench.sv
/*
  p3g_port3_bench: directed scenarios for the port 3 pin multiplexer.
  assumes: pin world model on the pads; the checker binds itself to the block.
*/
`timescale 1ns/10ps
module p3g_port3_bench
  import p3g_pkg::*;
;
  logic core_clk, rst_n, reg_wr_en, reg_rd_en, strobe_out, serial_two_data_out;
  logic serial_two_clock_out, serial_one_data_out, serial_one_clock_out, serial_one_clock_oe;
  logic chip_select_n, serial_two_data_in, serial_two_clock_in, serial_one_data_in;
  logic serial_one_clock_in;
  logic [15:0] reg_addr;
  logic [7:0] reg_wr_data, reg_rd_data, pad_in, pad_out, pad_oe, pad_pullup, ext_val, ext_en;
  logic [2:0] serial_clock_source_field;
  int error_cnt, n_tests;

  p3g_port3 i_dut (.core_clk, .rst_n, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en,
    .reg_rd_data, .pad_in, .pad_out, .pad_oe, .pad_pullup, .strobe_out, .serial_two_data_out,
    .serial_two_clock_out, .serial_clock_source_field, .serial_one_data_out,
    .serial_one_clock_out, .serial_one_clock_oe, .chip_select_n, .serial_two_data_in,
    .serial_two_clock_in, .serial_one_data_in, .serial_one_clock_in);
  p3g_pin_world i_world (.core_clk, .pad_out, .pad_oe, .pad_pullup, .ext_val, .ext_en, .pad_in);

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe, so it is taken there
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    #1;
    chk(what, reg_rd_data, exp);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  function automatic logic [7:0] fin();
    return {3'b000, chip_select_n, serial_two_data_in, serial_two_clock_in,
            serial_one_data_in, serial_one_clock_in};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(P3G_DATA_LATCH_ADDR, 8'h00, "latch");
    rdc(P3G_PULLUP_ADDR, 8'h00, "pullup");
    rdc(P3G_FUNC_SEL_ADDR, 8'h00, "fsel");
    rdc(P3G_DIR_ADDR, 8'hff, "dir");
    chk("oe", pad_oe, 8'h00);
    chk("pull", pad_pullup, 8'h00);
    chk("fin", fin(), 8'h1f);
  endtask

  task automatic t_gpio();
    wr(P3G_DIR_ADDR, 8'hff);
    wr(P3G_DATA_LATCH_ADDR, 8'ha5);
    wt(2);
    chk("oe", pad_oe, 8'hff);
    chk("out", pad_out, 8'ha5);
    rdc(P3G_DATA_LATCH_ADDR, 8'ha5, "rd out");
    rdc(P3G_DIR_ADDR, 8'hff, "dir");
    wr(P3G_DIR_ADDR, 8'h0f);
    ext_val <= 8'h3c;
    wt(4);
    chk("oe", pad_oe, 8'h0f);
    rdc(P3G_DATA_LATCH_ADDR, 8'h35, "rd mix");
    // release the upper pins so only the pull-up holds them
    ext_en <= 8'h0f;
    wr(P3G_PULLUP_ADDR, 8'hf3);
    wt(4);
    chk("pull", pad_pullup, 8'hf0);
    rdc(P3G_DATA_LATCH_ADDR, 8'hf5, "rd pulled");
    rdc(P3G_PULLUP_ADDR, 8'hf3, "pullup");
  endtask

  task automatic t_func();
    ext_en <= 8'hff;
    ext_val <= 8'h00;
    strobe_out <= 1'b1;
    serial_one_data_out <= 1'b1;
    serial_two_clock_out <= 1'b1;
    serial_one_clock_out <= 1'b1;
    serial_one_clock_oe <= 1'b1;
    serial_clock_source_field <= P3G_CKS_EXT_IN;
    wr(P3G_DIR_ADDR, 8'h00);
    wr(P3G_DATA_LATCH_ADDR, 8'hff);
    wr(P3G_PULLUP_ADDR, 8'hff);
    wr(P3G_FUNC_SEL_ADDR, 8'hff);
    wt(4);
    rdc(P3G_FUNC_SEL_ADDR, 8'hff, "fsel");
    chk("oe", pad_oe, 8'h65);
    chk("out", pad_out & pad_oe, 8'h45);
    chk("pull", pad_pullup, 8'h9a);
    chk("fin", fin(), 8'h01);
    rdc(P3G_DATA_LATCH_ADDR, 8'h45, "rd pins");
    serial_clock_source_field <= 3'h0;
    serial_one_clock_oe <= 1'b0;
    serial_two_data_out <= 1'b1;
    wt(4);
    chk("oe", pad_oe, 8'h6c);
    chk("out", pad_out & pad_oe, 8'h6c);
    chk("fin", fin(), 8'h04);
    wr(P3G_FUNC_SEL_ADDR, 8'h00);
    wt(4);
    chk("oe", pad_oe, 8'h00);
    chk("fin", fin(), 8'h1f);
  endtask

  task automatic t_bus();
    wr(16'hffcb, 8'hff);
    rdc(16'hffcb, 8'h00, "unmapped");
    rdc(P3G_FUNC_SEL_ADDR, 8'h00, "fsel");
    // write then read with no idle cycle between the strobes
    @(posedge core_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= P3G_PULLUP_ADDR;
    reg_wr_data <= 8'h3c;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    #1;
    chk("b2b", reg_rd_data, 8'h3c);
    // second reset in mid-run, raised and dropped on clock edges
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    // latch held all ones and pull-ups on pins 2 to 5 were on before the reset
    chk("out", pad_out, 8'h00);
    chk("pull", pad_pullup, 8'h00);
    chk("fin", fin(), 8'h1f);
    rdc(P3G_PULLUP_ADDR, 8'h00, "pullup");
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // the whole run is under a hundred cycles; the limit leaves ample margin
  initial begin
    repeat (3000) @(posedge core_clk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    error_cnt = 0;
    n_tests = 0;
    rst_n = 1'b0;
    {reg_wr_en, reg_rd_en, strobe_out, serial_two_data_out, serial_two_clock_out} = 5'h00;
    {serial_one_data_out, serial_one_clock_out, serial_one_clock_oe} = 3'h0;
    serial_clock_source_field = 3'h0;
    reg_addr = 16'h0000;
    reg_wr_data = 8'h00;
    ext_val = 8'h00;
    ext_en = 8'hff;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_gpio();
    t_func();
    t_bus();
    give_verdict();
  end
endmodule
